// File: design/lpmc_pkg.sv
// Package of constants for the low power mode controller
package lpmc_pkg;

  // ****************************************************************
  // Register map (APB byte addresses)
  // ****************************************************************
  localparam logic [7:0] LPMC_CTRL_OFF   = 8'h00;
  localparam logic [7:0] LPMC_STATUS_OFF = 8'h04;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int LPMC_CTRL_IRQEN_BIT = 0;
  localparam int LPMC_CTRL_LONG_BIT  = 1;
  localparam int LPMC_CTRL_AUX_BIT   = 2;
  localparam logic [2:0] LPMC_CTRL_RESET = 3'h0;

  // ****************************************************************
  // Status register fields
  // ****************************************************************
  localparam int LPMC_STAT_MODE_LSB = 0;
  localparam int LPMC_STAT_NMIW_BIT = 4;
  localparam int LPMC_STAT_SKIP_BIT = 5;
  localparam int LPMC_STAT_AUX_BIT  = 6;

  // ****************************************************************
  // Oscillator start-up delay, in internal clock cycles
  // ****************************************************************
  localparam int LPMC_SHORT_DELAY_CYC = 2048;
  localparam int LPMC_LONG_DELAY_CYC  = 32768;
  localparam int LPMC_DLY_W           = 16;

  // ****************************************************************
  // Core context at entry
  // ****************************************************************
  localparam logic [1:0] LPMC_CTX_MAIN = 2'h0;
  localparam logic [1:0] LPMC_CTX_IRQ  = 2'h1;
  localparam logic [1:0] LPMC_CTX_NMI  = 2'h2;

  typedef enum logic [3:0] {
    LPMC_RUN   = 4'h1,
    LPMC_WAIT  = 4'h2,
    LPMC_STOP  = 4'h4,
    LPMC_START = 4'h8
  } lpmc_state_t;

endpackage

// File: design/lpmc_delay_counter.sv
// Oscillator stabilisation delay counter
`timescale 1ns/1ps
module lpmc_delay_counter
  import lpmc_pkg::*;
#(
  parameter int LONG_CYC = LPMC_LONG_DELAY_CYC
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic start,
  input  wire logic longSel,
  output logic      busy,
  output logic      done
);

  localparam logic [LPMC_DLY_W-1:0] SHORT_LOAD = LPMC_DLY_W'(LPMC_SHORT_DELAY_CYC - 1);
  localparam logic [LPMC_DLY_W-1:0] LONG_LOAD  = LPMC_DLY_W'(LONG_CYC - 1);

  logic [LPMC_DLY_W-1:0] count;

  // Busy for exactly the selected number of cycles, done on the last one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
      busy  <= 1'b0;
    end else if (start) begin
      count <= longSel ? LONG_LOAD : SHORT_LOAD;
      busy  <= 1'b1;
    end else if (busy) begin
      if (count == '0) begin
        busy <= 1'b0;
      end else begin
        count <= count - 1'b1;
      end
    end
  end

  assign done = busy && (count == '0);

endmodule

// File: design/lpmc_controller.sv
// Low power mode controller: RUN, WAIT and STOP sequencing with APB registers
`timescale 1ns/1ps

module lpmc_controller
  import lpmc_pkg::*;
#(
  parameter int LONG_DELAY_CYC = LPMC_LONG_DELAY_CYC
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        waitExec,
  input  wire logic        stopExec,
  input  wire logic [1:0]  coreCtx,
  input  wire logic        periphIrq,
  input  wire logic        extClkPeriphIrq,
  input  wire logic        extIrq,
  input  wire logic        nmiIrq,
  input  wire logic        nmiPin,
  input  wire logic        watchdogActive,
  input  wire logic        stopOverrideOption,
  output logic             coreHalt,
  output logic             mainOscRun,
  output logic             auxLowFreqOscRun,
  output logic             periphClkEnable,
  output logic             watchdogFreeze,
  output logic             instrSkip,
  output logic             resumePulse,
  output logic             resumeVector,
  output logic             resumeNmi
);

  // ****************************************************************
  // Signals
  // ****************************************************************
  lpmc_state_t state;
  lpmc_state_t next_state;
  logic        globalIrqEnable;
  logic        delayLong;
  logic        auxLowFreqOscSel;
  logic        nmiMeta;
  logic        nmiLevel;
  logic [1:0]  entryCtx;
  logic        auxAtEntry;
  logic        nmiWake;
  logic        skipSeen;
  logic        pending;
  logic        stopEff;
  logic        enterReq;
  logic        wakeWait;
  logic        wakeStop;
  logic        dlyBusy;
  logic        dlyDone;
  logic        setupRd;
  logic        accWr;
  logic        mapped;

  // ****************************************************************
  // NMI pin synchroniser
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nmiMeta  <= 1'b0;
      nmiLevel <= 1'b0;
    end else begin
      nmiMeta  <= nmiPin;
      nmiLevel <= nmiMeta;
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign mapped  = (paddr == LPMC_CTRL_OFF) || (paddr == LPMC_STATUS_OFF);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign setupRd = psel && !penable && !pwrite;
  assign accWr   = psel && penable && pwrite && (paddr == LPMC_CTRL_OFF);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      globalIrqEnable  <= LPMC_CTRL_RESET[LPMC_CTRL_IRQEN_BIT];
      delayLong        <= LPMC_CTRL_RESET[LPMC_CTRL_LONG_BIT];
      auxLowFreqOscSel <= LPMC_CTRL_RESET[LPMC_CTRL_AUX_BIT];
    end else if (accWr) begin
      globalIrqEnable  <= pwdata[LPMC_CTRL_IRQEN_BIT];
      delayLong        <= pwdata[LPMC_CTRL_LONG_BIT];
      auxLowFreqOscSel <= pwdata[LPMC_CTRL_AUX_BIT];
    end
  end

  // Read data captured in setup phase; enable bit reads zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0;
    end else if (setupRd) begin
      prdata <= 32'h0;
      if (paddr == LPMC_CTRL_OFF) begin
        prdata[LPMC_CTRL_LONG_BIT] <= delayLong;
        prdata[LPMC_CTRL_AUX_BIT]  <= auxLowFreqOscSel;
      end else if (paddr == LPMC_STATUS_OFF) begin
        prdata[LPMC_STAT_MODE_LSB +: 4] <= state;
        prdata[LPMC_STAT_NMIW_BIT]      <= nmiWake;
        prdata[LPMC_STAT_SKIP_BIT]      <= skipSeen;
        prdata[LPMC_STAT_AUX_BIT]       <= auxAtEntry;
      end
    end
  end

  // ****************************************************************
  // Entry and wake conditions
  // ****************************************************************
  assign pending  = (globalIrqEnable && (periphIrq || extClkPeriphIrq || extIrq)) || nmiIrq;
  assign stopEff  = stopExec && (!watchdogActive || (stopOverrideOption && nmiLevel));
  assign enterReq = (waitExec || stopExec) && !pending;
  assign wakeWait = globalIrqEnable && (periphIrq || extClkPeriphIrq || extIrq || nmiIrq);
  assign wakeStop = globalIrqEnable && (extClkPeriphIrq || extIrq || nmiIrq);

  // ****************************************************************
  // Mode state machine
  // ****************************************************************
  always_comb begin
    next_state = state;
    case (state)
      LPMC_RUN: begin
        if (enterReq) begin
          next_state = stopEff ? LPMC_STOP : LPMC_WAIT;
        end
      end
      LPMC_WAIT: begin
        if (wakeWait) begin
          next_state = LPMC_RUN;
        end
      end
      LPMC_STOP: begin
        if (wakeStop) begin
          next_state = LPMC_START;
        end
      end
      LPMC_START: begin
        if (dlyDone) begin
          next_state = LPMC_RUN;
        end
      end
      default: begin
        next_state = LPMC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= LPMC_RUN;
    end else begin
      state <= next_state;
    end
  end

  lpmc_delay_counter #(
    .LONG_CYC (LONG_DELAY_CYC)
  ) u_delay (
    .clk     (clk),
    .arst_n  (arst_n),
    .start   ((state == LPMC_STOP) && wakeStop),
    .longSel (delayLong),
    .busy    (dlyBusy),
    .done    (dlyDone)
  );

  // ****************************************************************
  // Context captured at entry and at wake
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      entryCtx   <= LPMC_CTX_MAIN;
      auxAtEntry <= 1'b0;
    end else if (state == LPMC_RUN && enterReq) begin
      entryCtx   <= coreCtx;
      auxAtEntry <= auxLowFreqOscSel;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nmiWake <= 1'b0;
    end else if ((state == LPMC_WAIT && wakeWait) || (state == LPMC_STOP && wakeStop)) begin
      nmiWake <= nmiIrq;
    end
  end

  // Skip flag stays set until the next real entry
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      skipSeen <= 1'b0;
    end else if (state == LPMC_RUN && (waitExec || stopExec)) begin
      skipSeen <= pending;
    end
  end

  // ****************************************************************
  // Restart outputs
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      resumePulse  <= 1'b0;
      resumeVector <= 1'b0;
      resumeNmi    <= 1'b0;
      instrSkip    <= 1'b0;
    end else begin
      instrSkip   <= (state == LPMC_RUN) && (waitExec || stopExec) && pending;
      resumePulse <= (state != LPMC_RUN) && (next_state == LPMC_RUN);
      if ((state != LPMC_RUN) && (next_state == LPMC_RUN)) begin
        resumeVector <= (entryCtx == LPMC_CTX_MAIN) ||
                        ((entryCtx == LPMC_CTX_IRQ) && ((state == LPMC_WAIT) ? nmiIrq : nmiWake));
        resumeNmi    <= (entryCtx == LPMC_CTX_NMI);
      end
    end
  end

  // ****************************************************************
  // Clock and halt controls
  // ****************************************************************
  // Nothing here resets core, RAM or peripheral state on entry or exit
  assign coreHalt         = (state != LPMC_RUN);
  assign mainOscRun       = (state == LPMC_RUN) ? !auxLowFreqOscSel :
                            (state == LPMC_WAIT) ? !auxAtEntry : (state == LPMC_START);
  assign auxLowFreqOscRun = (state == LPMC_RUN) ? auxLowFreqOscSel :
                            (state == LPMC_WAIT) && auxAtEntry;
  assign periphClkEnable  = (state == LPMC_RUN) || (state == LPMC_WAIT);
  assign watchdogFreeze   = (state == LPMC_STOP) || (state == LPMC_START);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic        aliveQ;
  logic [15:0] startCyc;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aliveQ   <= 1'b0;
      startCyc <= 16'h0;
    end else begin
      aliveQ   <= 1'b1;
      startCyc <= (state == LPMC_START) ? startCyc + 16'h1 : 16'h0;
    end
  end

  reset_run_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(aliveQ) |-> (!coreHalt && periphClkEnable && !watchdogFreeze))
    else $error("not in run after reset");

  wait_entry_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state == LPMC_RUN && waitExec && !stopExec && !pending) |=> (coreHalt && periphClkEnable && !watchdogFreeze))
    else $error("wait entry wrong");

  wait_osc_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state == LPMC_RUN && enterReq && !stopEff) |=> (auxLowFreqOscRun == $past(auxLowFreqOscSel))
      && (mainOscRun != auxLowFreqOscRun))
    else $error("wait oscillator not the entry one");

  stop_osc_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state == LPMC_STOP) |-> (!mainOscRun && !auxLowFreqOscRun && !periphClkEnable && coreHalt))
    else $error("oscillator running in stop");

  stop_wake_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state == LPMC_STOP && !(globalIrqEnable && (extClkPeriphIrq || extIrq || nmiIrq))) |=> (state == LPMC_STOP))
    else $error("stop left without valid wake");

  stop_delay_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state == LPMC_START && next_state == LPMC_RUN) |->
      (startCyc == (delayLong ? 16'(LONG_DELAY_CYC - 1) : 16'(LPMC_SHORT_DELAY_CYC - 1))))
    else $error("start-up delay length wrong");

  wdg_wait_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state == LPMC_RUN && stopExec && !pending && watchdogActive && !(stopOverrideOption && nmiLevel))
      |=> (state == LPMC_WAIT && !watchdogFreeze))
    else $error("stop not turned into wait");

  irq_mask_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state == LPMC_WAIT && !globalIrqEnable) |=> coreHalt)
    else $error("woke with interrupts disabled");

  nmi_ctx_a: assert property (@(posedge clk) disable iff (!arst_n)
    (resumePulse && entryCtx == LPMC_CTX_NMI) |-> (resumeNmi && !resumeVector))
    else $error("nmi context restart vectored");

  main_ctx_a: assert property (@(posedge clk) disable iff (!arst_n)
    (resumePulse && entryCtx == LPMC_CTX_MAIN) |-> resumeVector)
    else $error("main context restart not vectored");

  pend_skip_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state == LPMC_RUN && (waitExec || stopExec) && pending) |=> (!coreHalt && instrSkip))
    else $error("entered despite pending request");

  halt_release_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state == LPMC_WAIT && wakeWait) |=> (!coreHalt && resumePulse) ##1 !resumePulse)
    else $error("halt not released on wake");

  wait_periph_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state == LPMC_WAIT && globalIrqEnable && periphIrq) |=> (state == LPMC_RUN))
    else $error("peripheral request did not end wait");

  start_busy_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state == LPMC_START) |-> (dlyBusy && mainOscRun && coreHalt))
    else $error("start-up delay not running");

  irq_ctx_a: assert property (@(posedge clk) disable iff (!arst_n)
    (resumePulse && entryCtx == LPMC_CTX_IRQ && !nmiWake) |-> (!resumeVector && !resumeNmi))
    else $error("interrupt context restart vectored");

  nmi_first_a: assert property (@(posedge clk) disable iff (!arst_n)
    (resumePulse && entryCtx == LPMC_CTX_IRQ && nmiWake) |-> (resumeVector && !resumeNmi))
    else $error("nmi wake in interrupt context not vectored");

  write_only_a: assert property (@(posedge clk) disable iff (!arst_n)
    (psel && !penable && !pwrite && paddr == LPMC_CTRL_OFF) |=> !prdata[LPMC_CTRL_IRQEN_BIT])
    else $error("global enable readable");

endmodule

// File: tb/lpmc_core_model.sv
// Core model that executes WAIT and STOP for the bench
`timescale 1ns/1ps
module lpmc_core_model
  import lpmc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       cmdWait,
  input  wire logic       cmdStop,
  input  wire logic [1:0] cmdCtx,
  input  wire logic       coreHalt,
  output logic            waitExec,
  output logic            stopExec,
  output logic      [1:0] coreCtx
);
  // A halted core executes nothing; one pulse per instruction
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      waitExec <= 1'b0;
      stopExec <= 1'b0;
      coreCtx  <= LPMC_CTX_MAIN;
    end else begin
      waitExec <= cmdWait & ~coreHalt & ~waitExec & ~stopExec;
      stopExec <= cmdStop & ~coreHalt & ~waitExec & ~stopExec;
      coreCtx  <= cmdCtx;
    end
  end
endmodule

// File: tb/lpmc_controller_tb.sv
// Self-checking bench for the low power mode controller
`timescale 1ns/1ps
module lpmc_controller_tb;
  import lpmc_pkg::*;
  localparam int LONG_CYC = 16;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        cmdWait, cmdStop, waitExec, stopExec;
  logic [1:0]  cmdCtx, coreCtx;
  logic [3:0]  src;
  logic        nmiPin, watchdogActive, stopOverrideOption;
  logic        coreHalt, mainOscRun, auxLowFreqOscRun, periphClkEnable, watchdogFreeze;
  logic        instrSkip, resumePulse, resumeVector, resumeNmi;
  logic [2:0]  e;
  logic [2:0]  expq[$];
  int          err_total, num_checks, i;

  lpmc_controller #(.LONG_DELAY_CYC(LONG_CYC)) lpmc_controller_inst (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .waitExec(waitExec), .stopExec(stopExec), .coreCtx(coreCtx), .periphIrq(src[0]),
    .extClkPeriphIrq(src[1]), .extIrq(src[2]), .nmiIrq(src[3]), .nmiPin(nmiPin),
    .watchdogActive(watchdogActive), .stopOverrideOption(stopOverrideOption),
    .coreHalt(coreHalt), .mainOscRun(mainOscRun), .auxLowFreqOscRun(auxLowFreqOscRun),
    .periphClkEnable(periphClkEnable), .watchdogFreeze(watchdogFreeze), .instrSkip(instrSkip),
    .resumePulse(resumePulse), .resumeVector(resumeVector), .resumeNmi(resumeNmi));

  lpmc_core_model lpmc_core_model_inst (
    .clk(clk), .arst_n(arst_n), .cmdWait(cmdWait), .cmdStop(cmdStop), .cmdCtx(cmdCtx),
    .coreHalt(coreHalt), .waitExec(waitExec), .stopExec(stopExec), .coreCtx(coreCtx));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic timeout();
    err_total++;
    $display("BAD t=%0t wait ran out", $time);
    tally_and_finish();
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 50) timeout();
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Executes WAIT or STOP and notes the resume or skip result
  task automatic exec(input logic stp, input logic [1:0] c, input logic [2:0] x);
    @(posedge clk);
    cmdWait <= ~stp;
    cmdStop <= stp;
    cmdCtx <= c;
    expq.push_back(x);
    @(posedge clk);
    cmdWait <= 1'b0;
    cmdStop <= 1'b0;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      #1;
      if (coreHalt === 1'b1 || instrSkip === 1'b1) break;
    end
    if (i == 20) timeout();
    @(posedge clk);
  endtask

  // Raises a request (s < 0: none) and counts edges until the core runs
  task automatic wake(input int s, input int n);
    int c;
    repeat ($urandom_range(1, 5)) @(posedge clk);
    if (s >= 0) src[s] <= 1'b1;
    c = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
      if (c > 3000) timeout();
    end while (coreHalt !== 1'b0);
    if (n >= 0) chk(c, n);
    @(posedge clk);
    src <= 4'h0;
  endtask

  always @(posedge clk) begin
    if (instrSkip === 1'b1 || resumePulse === 1'b1) begin
      if (expq.size() == 0) begin
        err_total++;
        $display("BAD t=%0t unexpected result", $time);
      end else begin
        e = expq.pop_front();
        if (instrSkip === 1'b1) chk(instrSkip, e[2]);
        else chk({resumeVector, resumeNmi}, e[1:0]);
      end
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {psel, penable, pwrite, cmdWait, cmdStop, nmiPin, watchdogActive, stopOverrideOption} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    cmdCtx = 2'h0;
    src = 4'h0;
    arst_n = 1'b0;
    err_total = 0;
    num_checks = 0;
    void'($urandom(32'h0dd3));
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    chk({coreHalt, mainOscRun, auxLowFreqOscRun, periphClkEnable, watchdogFreeze}, 5'h0a);
    apb(1'b0, LPMC_STATUS_OFF, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, LPMC_CTRL_OFF, 32'h1);
    apb(1'b0, LPMC_CTRL_OFF, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    $display("test reset done");
    exec(1'b0, LPMC_CTX_MAIN, 3'h2);
    chk({mainOscRun, periphClkEnable, auxLowFreqOscRun}, 3'h6);
    wake(2, 1);
    $display("test wait done");
    apb(1'b1, LPMC_CTRL_OFF, 32'h5);
    exec(1'b0, LPMC_CTX_IRQ, 3'h0);
    chk({mainOscRun, auxLowFreqOscRun}, 2'h1);
    wake(0, 1);
    $display("test aux wait done");
    apb(1'b1, LPMC_CTRL_OFF, 32'h0);
    exec(1'b0, LPMC_CTX_IRQ, 3'h2);
    src[3] <= 1'b1;
    repeat (20) @(posedge clk);
    chk(coreHalt, 1'b1);
    apb(1'b1, LPMC_CTRL_OFF, 32'h1);
    wake(-1, -1);
    $display("test nmi done");
    @(posedge clk);
    src[1] <= 1'b1;
    exec(1'b1, LPMC_CTX_MAIN, 3'h4);
    chk(coreHalt, 1'b0);
    src <= 4'h0;
    $display("test skip done");
    apb(1'b1, LPMC_CTRL_OFF, 32'h3);
    exec(1'b1, LPMC_CTX_NMI, 3'h1);
    chk({mainOscRun, periphClkEnable, watchdogFreeze}, 3'h1);
    src[0] <= 1'b1;
    repeat (10) @(posedge clk);
    chk(coreHalt, 1'b1);
    src <= 4'h0;
    wake($urandom_range(1, 2), LONG_CYC + 1);
    apb(1'b0, LPMC_CTRL_OFF, 32'h0);
    chk(rd, 32'h2);
    $display("test stop done");
    watchdogActive <= 1'b1;
    exec(1'b1, LPMC_CTX_MAIN, 3'h2);
    chk({periphClkEnable, watchdogFreeze}, 2'h2);
    wake(2, 1);
    stopOverrideOption <= 1'b1;
    nmiPin <= 1'b1;
    apb(1'b1, LPMC_CTRL_OFF, 32'h1);
    exec(1'b1, LPMC_CTX_MAIN, 3'h2);
    chk({periphClkEnable, watchdogFreeze}, 2'h1);
    wake(2, LPMC_SHORT_DELAY_CYC + 1);
    $display("test watchdog done");
    repeat (3) @(posedge clk);
    chk(32'(expq.size()), 32'h0);
    tally_and_finish();
  end
endmodule
